// ---- inc/spg_pkg.sv ----
// Purpose: Shared constants and types for the SATA power and legacy glue.
// Assumes: Controller clock of 100 MHz.
// Notes:   Every number used by the glue is named once here.
`default_nettype none
package spg_pkg;

	// ************************************************************
	// Power states and bus spaces
	// ************************************************************
	localparam logic [1:0] PM_D0 = 2'h0;
	localparam logic [1:0] PM_D3 = 2'h3;
	localparam logic [1:0] PM_RESET = PM_D0;
	localparam logic [1:0] SP_CFG = 2'h0;
	localparam logic [1:0] SP_MEM = 2'h1;
	localparam logic [1:0] SP_IO = 2'h2;

	// ************************************************************
	// IDE I/O ranges
	// ************************************************************
	localparam logic [15:0] PRI_CMD_LEG = 16'h01f0;
	localparam logic [15:0] PRI_CTL_LEG = 16'h03f6;
	localparam logic [15:0] SEC_CMD_LEG = 16'h0170;
	localparam logic [15:0] SEC_CTL_LEG = 16'h0376;
	localparam logic [4:0] CMD_LEN = 5'h08;
	localparam logic [4:0] CTL_LEG_LEN = 5'h01;
	localparam logic [4:0] CTL_NAT_LEN = 5'h04;
	localparam logic [4:0] BM_LEN = 5'h10;
	localparam int BM_CHAN_BIT = 3;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [3:0] TRAP_EN_RESET = 4'h0;
	localparam logic [3:0] PORT_EN_RESET = 4'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int PARTIAL_EXIT_NS = 10;
	localparam int SLUMBER_EXIT_MS = 10;
	localparam int PARTIAL_CYC = (PARTIAL_EXIT_NS / CLK_PERIOD_NS) < 1 ?
		1 : (PARTIAL_EXIT_NS / CLK_PERIOD_NS);
	localparam int SLUMBER_CYC = (SLUMBER_EXIT_MS * 1000000) /
		CLK_PERIOD_NS;
	localparam int WCNT_W = 20;

	// ************************************************************
	// Link power state of one port
	// ************************************************************
	typedef enum logic [1:0] {
		LK_ACTIVE,
		LK_PARTIAL,
		LK_SLUMBER,
		LK_WAKING
	} spg_link_t;

endpackage
`default_nettype wire

// ---- design/spg_top.sv ----
// Purpose: Power management and legacy support glue of a SATA host.
// Assumes: All inputs synchronous to clk; pulses last one cycle.
// Notes:   Open-drain pins are given as a level output plus an enable.
`timescale 1ns/1ns
`default_nettype none
module spg_top #(
	parameter int NPORT = 4,
	parameter int PART_CYC = spg_pkg::PARTIAL_CYC,
	parameter int SLUM_CYC = spg_pkg::SLUMBER_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               legacy_mode,
	input  wire logic               pm_state_wr,
	input  wire logic [1:0]         pm_state_wdata,
	output logic      [1:0]         pm_state,
	input  wire logic               acc_valid,
	input  wire logic [1:0]         acc_space,
	input  wire logic [15:0]        acc_addr,
	output logic                    acc_fwd,
	output logic                    acc_master_abort,
	output logic                    acc_trapped,
	input  wire logic [15:0]        primary_cmd_base,
	input  wire logic [15:0]        primary_ctl_base,
	input  wire logic [15:0]        secondary_cmd_base,
	input  wire logic [15:0]        secondary_ctl_base,
	input  wire logic [15:0]        bm_base,
	input  wire logic               pri_drv_sel,
	input  wire logic               sec_drv_sel,
	input  wire logic               trap_en_wr,
	input  wire logic [3:0]         trap_en_wdata,
	output logic      [3:0]         trap_en,
	input  wire logic               act_clr_wr,
	input  wire logic [3:0]         act_clr_mask,
	output logic      [3:0]         trap_activity,
	output logic                    system_mgmt_irq_n,
	input  wire logic [7:0]         irq_status,
	input  wire logic [7:0]         irq_enable,
	input  wire logic               hotplug_evt,
	input  wire logic               pme_req,
	output logic                    intr_out,
	output logic                    pme_n_o,
	output logic                    pme_n_oe,
	input  wire logic               port_en_wr,
	input  wire logic [NPORT-1:0]   port_en_wdata,
	output logic      [NPORT-1:0]   port_enable_bit,
	input  wire logic [NPORT-1:0]   phy_detect,
	output logic      [NPORT-1:0]   port_present_bit,
	output logic      [NPORT-1:0]   port_phy_power,
	input  wire logic [NPORT-1:0]   drv_pm_req,
	input  wire logic [NPORT-1:0]   drv_pm_slumber,
	output logic      [NPORT-1:0]   drv_pm_ack,
	input  wire logic [NPORT-1:0]   drv_wake,
	input  wire logic [NPORT-1:0]   cable_use_req,
	input  wire logic [NPORT-1:0]   phy_ready,
	output logic      [NPORT-1:0]   com_wake,
	output logic      [NPORT-1:0]   cable_grant,
	input  wire logic [NPORT-1:0]   drive_busy_flag,
	output logic                    drive_activity_led_n_o,
	output logic                    drive_activity_led_n_oe
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [1:0]                 pm;
		logic [3:0]                 trap_en;
		logic [3:0]                 act;
		logic                       smi_n;
		logic                       fwd;
		logic                       abort;
		logic                       trap;
		logic                       intr;
		logic                       pme_oe;
		logic                       led_oe;
		logic [NPORT-1:0]           pen;
		logic [NPORT-1:0]           pres;
		logic [NPORT-1:0]           ack;
		logic [NPORT-1:0]           wake;
		logic [NPORT-1:0]           grant;
		spg_pkg::spg_link_t [NPORT-1:0] lk;
		logic [NPORT-1:0][spg_pkg::WCNT_W-1:0] wcnt;
	} spg_state_t;

	spg_state_t s_r;
	spg_state_t s_nxt;

	// Returns true when addr falls in [base, base+len).
	function automatic logic spg_in_range(
		input logic [15:0] addr,
		input logic [15:0] base,
		input logic [4:0]  len
	);
		logic [16:0] top;
		top = {1'b0, base} + {12'h000, len};
		spg_in_range = ({1'b0, addr} >= {1'b0, base}) &&
			({1'b0, addr} < top);
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	// Computes every register of the glue from inputs and state.
	always_comb
	begin
		logic       d3;
		logic [3:0] hit;
		logic       bm_hit;
		logic [1:0] dev;
		logic       io_ok;
		logic       tr;
		d3 = 1'b0;
		hit = 4'h0;
		bm_hit = 1'b0;
		dev = 2'h0;
		io_ok = 1'b0;
		tr = 1'b0;
		s_nxt = s_r;

		// Power state is only moved by config writes; no reset on exit.
		if (pm_state_wr)
		begin
			s_nxt.pm = pm_state_wdata;
		end
		d3 = (s_r.pm == spg_pkg::PM_D3);

		if (trap_en_wr)
		begin
			s_nxt.trap_en = trap_en_wdata;
		end
		if (port_en_wr)
		begin
			s_nxt.pen = port_en_wdata;
		end

		// Decode which IDE range an I/O cycle touches.
		hit[0] = spg_in_range(acc_addr, spg_pkg::PRI_CMD_LEG,
			spg_pkg::CMD_LEN) || spg_in_range(acc_addr,
			primary_cmd_base, spg_pkg::CMD_LEN);
		hit[1] = spg_in_range(acc_addr, spg_pkg::PRI_CTL_LEG,
			spg_pkg::CTL_LEG_LEN) || spg_in_range(acc_addr,
			primary_ctl_base, spg_pkg::CTL_NAT_LEN);
		hit[2] = spg_in_range(acc_addr, spg_pkg::SEC_CMD_LEG,
			spg_pkg::CMD_LEN) || spg_in_range(acc_addr,
			secondary_cmd_base, spg_pkg::CMD_LEN);
		hit[3] = spg_in_range(acc_addr, spg_pkg::SEC_CTL_LEG,
			spg_pkg::CTL_LEG_LEN) || spg_in_range(acc_addr,
			secondary_ctl_base, spg_pkg::CTL_NAT_LEN);
		bm_hit = spg_in_range(acc_addr, bm_base, spg_pkg::BM_LEN);

		// The device is the channel's currently selected drive.
		if (hit[2] || hit[3])
		begin
			dev = {1'b1, sec_drv_sel};
		end
		else if (hit[0] || hit[1])
		begin
			dev = {1'b0, pri_drv_sel};
		end
		else if (acc_addr[spg_pkg::BM_CHAN_BIT])
		begin
			dev = {1'b1, sec_drv_sel};
		end
		else
		begin
			dev = {1'b0, pri_drv_sel};
		end

		// Access answers are one-cycle pulses after the request.
		s_nxt.fwd = 1'b0;
		s_nxt.abort = 1'b0;
		s_nxt.trap = 1'b0;
		s_nxt.smi_n = 1'b1;
		io_ok = acc_valid && (acc_space == spg_pkg::SP_IO) && !d3;
		if (acc_valid && (acc_space == spg_pkg::SP_CFG))
		begin
			s_nxt.fwd = 1'b1;
		end
		else if (acc_valid && d3)
		begin
			s_nxt.abort = 1'b1;
		end
		else if (io_ok && legacy_mode && (|hit) && s_r.trap_en[dev])
		begin
			tr = 1'b1;
		end
		else if (io_ok && legacy_mode && bm_hit && s_r.trap_en[dev])
		begin
			s_nxt.fwd = 1'b1;
			tr = 1'b1;
		end
		else if (acc_valid)
		begin
			s_nxt.fwd = 1'b1;
		end
		if (tr)
		begin
			s_nxt.trap = 1'b1;
			s_nxt.smi_n = 1'b0;
		end

		// Activity bits: write one clears, a new trap wins the clash.
		if (act_clr_wr)
		begin
			s_nxt.act = s_r.act & ~act_clr_mask;
		end
		if (tr)
		begin
			s_nxt.act[dev] = 1'b1;
		end

		// Interrupt: held off in D3, resumes from pending status in D0.
		s_nxt.intr = !d3 &&
			((|(irq_status & irq_enable)) ||
			(hotplug_evt && !legacy_mode));
		s_nxt.pme_oe = pme_req && !legacy_mode;
		s_nxt.led_oe = |drive_busy_flag;

		// Per-port link power handling; low power is entered only on a drive request.
		for (int p = 0; p < NPORT; p++)
		begin
			s_nxt.ack[p] = 1'b0;
			s_nxt.wake[p] = 1'b0;
			s_nxt.grant[p] = 1'b0;
			case (s_r.lk[p])
				spg_pkg::LK_ACTIVE:
				begin
					if (drv_pm_req[p])
					begin
						s_nxt.ack[p] = 1'b1;
						s_nxt.lk[p] = drv_pm_slumber[p] ?
							spg_pkg::LK_SLUMBER : spg_pkg::LK_PARTIAL;
					end
					else if (cable_use_req[p])
					begin
						s_nxt.grant[p] = 1'b1;
					end
				end
				spg_pkg::LK_PARTIAL,
				spg_pkg::LK_SLUMBER:
				begin
					if (drv_wake[p])
					begin
						s_nxt.lk[p] = spg_pkg::LK_ACTIVE;
					end
					else if (cable_use_req[p] && !d3)
					begin
						s_nxt.wake[p] = 1'b1;
						s_nxt.lk[p] = spg_pkg::LK_WAKING;
						s_nxt.wcnt[p] = (s_r.lk[p] == spg_pkg::LK_SLUMBER) ?
							spg_pkg::WCNT_W'(SLUM_CYC) :
							spg_pkg::WCNT_W'(PART_CYC);
					end
				end
				spg_pkg::LK_WAKING:
				begin
					if (phy_ready[p])
					begin
						s_nxt.lk[p] = spg_pkg::LK_ACTIVE;
						s_nxt.grant[p] = cable_use_req[p];
					end
					else if (s_r.wcnt[p] <= spg_pkg::WCNT_W'(1))
					begin
						// Recovery window missed: signal wake again.
						s_nxt.wake[p] = 1'b1;
						s_nxt.wcnt[p] = spg_pkg::WCNT_W'(SLUM_CYC);
					end
					else
					begin
						s_nxt.wcnt[p] = s_r.wcnt[p] -
							spg_pkg::WCNT_W'(1);
					end
				end
				default:
				begin
					s_nxt.lk[p] = spg_pkg::LK_ACTIVE;
				end
			endcase

			// Presence is sampled only while the link is awake.
			if (d3 || !s_r.pen[p])
			begin
				s_nxt.pres[p] = 1'b0;
			end
			else if (s_r.lk[p] == spg_pkg::LK_ACTIVE)
			begin
				s_nxt.pres[p] = phy_detect[p];
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// Registers the whole state; reset only from the platform.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.pm <= spg_pkg::PM_RESET;
			s_r.trap_en <= spg_pkg::TRAP_EN_RESET;
			s_r.pen <= spg_pkg::PORT_EN_RESET;
			s_r.smi_n <= 1'b1;
			for (int p = 0; p < NPORT; p++)
			begin
				s_r.lk[p] <= spg_pkg::LK_ACTIVE;
			end
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Drives ports from the registered state.
	assign pm_state = s_r.pm;
	assign acc_fwd = s_r.fwd;
	assign acc_master_abort = s_r.abort;
	assign acc_trapped = s_r.trap;
	assign trap_en = s_r.trap_en;
	assign trap_activity = s_r.act;
	assign system_mgmt_irq_n = s_r.smi_n;
	assign intr_out = s_r.intr;
	assign pme_n_o = 1'b0;
	assign pme_n_oe = s_r.pme_oe;
	assign port_enable_bit = s_r.pen;
	assign port_present_bit = s_r.pres;
	assign drv_pm_ack = s_r.ack;
	assign com_wake = s_r.wake;
	assign cable_grant = s_r.grant;

	// Port power off in D3; the open-drain enables are not gated by D3.
	assign port_phy_power = (s_r.pm == spg_pkg::PM_D3) ?
		'0 : s_r.pen;

	// Open drain LED: only ever pulls low.
	assign drive_activity_led_n_o = 1'b0;
	assign drive_activity_led_n_oe = s_r.led_oe;

endmodule
`default_nettype wire

// ---- dv/spg_checker.sv ----
// Purpose: Port assertions for the SATA power and legacy glue.
// Assumes: All relations sampled on the rising edge of clk.
// Notes:   Bound to every spg_top instance.
`timescale 1ns/1ns
`default_nettype none
module spg_checker #(
	parameter int NPORT = 4
) (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             legacy_mode,
	input wire logic [1:0]       pm_state,
	input wire logic             acc_valid,
	input wire logic [1:0]       acc_space,
	input wire logic [15:0]      acc_addr,
	input wire logic             acc_fwd,
	input wire logic             acc_master_abort,
	input wire logic             acc_trapped,
	input wire logic             pri_drv_sel,
	input wire logic             trap_en_wr,
	input wire logic [3:0]       trap_en,
	input wire logic             system_mgmt_irq_n,
	input wire logic             intr_out,
	input wire logic             pme_n_oe,
	input wire logic [NPORT-1:0] port_present_bit,
	input wire logic [NPORT-1:0] port_phy_power,
	input wire logic [NPORT-1:0] drv_pm_req,
	input wire logic [NPORT-1:0] drv_pm_ack,
	input wire logic [NPORT-1:0] drive_busy_flag,
	input wire logic             drive_activity_led_n_o,
	input wire logic             drive_activity_led_n_oe
);
	// ************************************************************
	// Relations between inputs and outputs
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_D3_ABORT: assert property (acc_valid && acc_space != 2'h0 &&
		pm_state == spg_pkg::PM_D3 |=> acc_master_abort && !acc_fwd)
		else $error("Access in D3 not aborted.");
	AST_CFG_FWD: assert property (acc_valid && acc_space == 2'h0
		|=> acc_fwd && !acc_master_abort)
		else $error("Config access not forwarded.");
	AST_TRAP_SMI: assert property (acc_trapped |-> !system_mgmt_irq_n &&
		$past(legacy_mode) && $past(acc_valid) &&
		$past(pm_state) != spg_pkg::PM_D3)
		else $error("Trap without cause or without SMI.");
	AST_NO_FWD: assert property (acc_valid && legacy_mode &&
		acc_space == 2'h2 && acc_addr[15:3] == 13'h003e && trap_en[0] &&
		!pri_drv_sel && pm_state != spg_pkg::PM_D3 |=> acc_trapped && !acc_fwd)
		else $error("Trapped access forwarded.");
	AST_NO_INT_D3: assert property (pm_state == spg_pkg::PM_D3 &&
		$past(pm_state) == spg_pkg::PM_D3 |-> !intr_out)
		else $error("Interrupt raised in D3.");
	AST_NO_PME: assert property (legacy_mode && $past(legacy_mode)
		|-> !pme_n_oe)
		else $error("Event pin pulled in legacy mode.");
	AST_ACK: assert property ((drv_pm_ack & ~$past(drv_pm_req)) == '0)
		else $error("Acknowledge without drive request.");
	AST_LED: assert property (drive_activity_led_n_oe ==
		($past(drive_busy_flag) != '0) && !drive_activity_led_n_o)
		else $error("Activity output wrong.");
	AST_D3_PORT: assert property (pm_state == spg_pkg::PM_D3 &&
		$past(pm_state) == spg_pkg::PM_D3 |->
		port_present_bit == '0 && port_phy_power == '0)
		else $error("Port alive in D3.");
	AST_KEEP: assert property (!$past(trap_en_wr) |-> $stable(trap_en))
		else $error("Trap enables changed without write.");
endmodule
bind spg_top spg_checker #(.NPORT(NPORT)) u_chk (.*);
`default_nettype wire

// ---- dv/spg_drive_model.sv ----
// Purpose: Behavioural drive on the far side of four SATA links.
// Assumes: Drive sees the host outputs on the rising clock edge.
// Notes:   slow selects a long wake answer, as from slumber.
`timescale 1ns/1ns
`default_nettype none
module spg_drive_model (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       slow,
	input wire logic [3:0] com_wake,
	input wire logic [3:0] drv_pm_ack,
	input wire logic [3:0] drive_use,
	output logic     [3:0] phy_ready,
	output logic     [3:0] drv_wake
);
	logic [2:0] cnt_r [4];

	// Ready falls on low power entry and returns once the wake is served.
	always @(posedge clk or posedge rst)
	begin
		drv_wake <= 4'h0;
		for (int i = 0; i < 4; i++)
		begin
			if (rst)
			begin
				phy_ready[i] <= 1'h1;
				cnt_r[i] <= 3'h0;
			end
			else if (drv_pm_ack[i])
				phy_ready[i] <= 1'h0;
			else if (com_wake[i])
			begin
				phy_ready[i] <= !slow;
				cnt_r[i] <= slow ? 3'h6 : 3'h0;
			end
			else if (cnt_r[i] != 3'h0)
			begin
				cnt_r[i] <= cnt_r[i] - 3'h1;
				phy_ready[i] <= (cnt_r[i] == 3'h1);
			end
			else if (drive_use[i] && !phy_ready[i])
			begin
				drv_wake[i] <= 1'h1;
				phy_ready[i] <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the SATA power and legacy glue.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Slumber wake count is shortened to 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {
		logic leg; logic d3; logic sel; logic [1:0] sp;
		logic [15:0] a; logic [3:0] te; logic [2:0] ex;
	} spg_row_t;
	logic clk, rst, legacy_mode, pm_state_wr, acc_valid, acc_fwd, slow;
	logic acc_master_abort, acc_trapped, pri_drv_sel, sec_drv_sel, w;
	logic trap_en_wr, act_clr_wr, system_mgmt_irq_n, hotplug_evt, pme_req;
	logic intr_out, pme_n_o, pme_n_oe, port_en_wr;
	logic drive_activity_led_n_o, drive_activity_led_n_oe;
	logic [1:0] pm_state_wdata, pm_state, acc_space;
	logic [15:0] acc_addr, primary_cmd_base, primary_ctl_base, bm_base;
	logic [15:0] secondary_cmd_base, secondary_ctl_base;
	logic [3:0] trap_en_wdata, trap_en, act_clr_mask, trap_activity;
	logic [3:0] port_en_wdata, port_enable_bit, phy_detect, port_present_bit;
	logic [3:0] port_phy_power, drv_pm_req, drv_pm_slumber, drv_pm_ack;
	logic [3:0] drv_wake, cable_use_req, phy_ready, com_wake, cable_grant;
	logic [3:0] drive_busy_flag, drive_use;
	logic [7:0] irq_status, irq_enable;
	int mismatches, comparisons, cyc, n;
	spg_row_t r;
	// Rows: legacy, D3, drive, space, address, trap enables, {fwd,abort,trap}.
	localparam spg_row_t ROWS [12] = '{
		'{1'h0, 1'h0, 1'h0, 2'h0, 16'h0000, 4'h0, 3'h4},
		'{1'h0, 1'h1, 1'h0, 2'h1, 16'h0000, 4'h0, 3'h2},
		'{1'h1, 1'h1, 1'h0, 2'h2, 16'h01f0, 4'h1, 3'h2},
		'{1'h0, 1'h1, 1'h0, 2'h0, 16'h0000, 4'h0, 3'h4},
		'{1'h1, 1'h0, 1'h0, 2'h2, 16'h01f3, 4'h1, 3'h1},
		'{1'h1, 1'h0, 1'h1, 2'h2, 16'h03f6, 4'h2, 3'h1},
		'{1'h1, 1'h0, 1'h1, 2'h2, 16'h0177, 4'h8, 3'h1},
		'{1'h1, 1'h0, 1'h0, 2'h2, 16'h0376, 4'h4, 3'h1},
		'{1'h0, 1'h0, 1'h0, 2'h2, 16'h01f0, 4'hf, 3'h4},
		'{1'h1, 1'h0, 1'h0, 2'h2, 16'h01f0, 4'he, 3'h4},
		'{1'h1, 1'h0, 1'h0, 2'h2, 16'h0500, 4'hf, 3'h4},
		'{1'h1, 1'h0, 1'h0, 2'h2, 16'hc00a, 4'h4, 3'h5}};

	spg_top #(.SLUM_CYC(20)) u_spg_top (.*);
	spg_drive_model u_spg_drive_model (.clk(clk), .rst(rst), .slow(slow),
		.com_wake(com_wake), .drv_pm_ack(drv_pm_ack), .drive_use(drive_use),
		.phy_ready(phy_ready), .drv_wake(drv_wake));

	// ************************************************************
	// Clock, timeout and helpers
	// ************************************************************
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Cuts a hang short as a counted mismatch.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			tally_and_finish;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic set_pm(input logic [1:0] s);
		pm_state_wdata = s;
		pm_state_wr = 1'h1;
		tick(1);
		pm_state_wr = 1'h0;
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		rst = 1'h1;
		{legacy_mode, pm_state_wr, pm_state_wdata, acc_valid, acc_space,
			acc_addr, pri_drv_sel, sec_drv_sel, trap_en_wr, trap_en_wdata,
			act_clr_wr, irq_status, irq_enable, hotplug_evt, pme_req,
			port_en_wr, port_en_wdata, phy_detect, drv_pm_req, drv_pm_slumber,
			cable_use_req, drive_busy_flag, drive_use, slow} = '0;
		act_clr_mask = 4'hf;
		primary_cmd_base = 16'h0400;
		primary_ctl_base = 16'h0408;
		secondary_cmd_base = 16'h0410;
		secondary_ctl_base = 16'h0418;
		bm_base = 16'hc000;
		tick(8);
		rst = 1'h0;
		tick(1);
		chk(pm_state, spg_pkg::PM_RESET);
		chk(trap_en, spg_pkg::TRAP_EN_RESET);
		chk(system_mgmt_irq_n, 1'h1);
		// Each row sets mode, power state and traps, then makes one access.
		foreach (ROWS[i])
		begin
			r = ROWS[i];
			legacy_mode = r.leg;
			pri_drv_sel = r.sel;
			sec_drv_sel = r.sel;
			trap_en_wdata = r.te;
			trap_en_wr = 1'h1;
			act_clr_wr = 1'h1;
			set_pm(r.d3 ? spg_pkg::PM_D3 : spg_pkg::PM_D0);
			trap_en_wr = 1'h0;
			act_clr_wr = 1'h0;
			acc_valid = 1'h1;
			acc_space = r.sp;
			acc_addr = r.a;
			tick(1);
			acc_valid = 1'h0;
			chk({acc_fwd, acc_master_abort, acc_trapped}, r.ex);
			chk(system_mgmt_irq_n, !r.ex[0]);
			chk(trap_activity, r.ex[0] ? r.te : 4'h0);
		end
		// Pending interrupt is held off in D3 and comes back in D0.
		irq_status = 8'h01;
		irq_enable = 8'h01;
		tick(2);
		chk(intr_out, 1'h1);
		set_pm(spg_pkg::PM_D3);
		tick(1);
		chk(intr_out, 1'h0);
		set_pm(spg_pkg::PM_D0);
		tick(1);
		chk(intr_out, 1'h1);
		chk(trap_en, ROWS[11].te);
		// Hot plug and event requests in legacy, then in the other mode.
		irq_status = 8'h00;
		hotplug_evt = 1'h1;
		pme_req = 1'h1;
		tick(2);
		chk({intr_out, pme_n_oe}, 2'h0);
		legacy_mode = 1'h0;
		tick(2);
		chk({intr_out, pme_n_oe, pme_n_o}, 3'h6);
		// Presence, activity output, and ports in D3.
		port_en_wdata = 4'hf;
		port_en_wr = 1'h1;
		// Links stay out of low power while presence is watched in AHCI mode.
		phy_detect = 4'h5;
		drive_busy_flag = 4'h2;
		tick(1);
		port_en_wr = 1'h0;
		tick(2);
		chk(port_present_bit, 4'h5);
		chk({drive_activity_led_n_oe, drive_activity_led_n_o}, 2'h2);
		drive_busy_flag = 4'h0;
		set_pm(spg_pkg::PM_D3);
		tick(1);
		chk(port_present_bit, 4'h0);
		chk(port_phy_power, 4'h0);
		chk(drive_activity_led_n_oe, 1'h0);
		set_pm(spg_pkg::PM_D0);
		tick(2);
		chk(port_present_bit, 4'h5);
		chk(port_enable_bit, 4'hf);
		chk(port_phy_power, 4'hf);
		// Partial on port 0, slumber on port 1, each woken by the host.
		for (int k = 0; k < 2; k++)
		begin
			slow = k[0];
			drv_pm_slumber[k] = k[0];
			drv_pm_req[k] = 1'h1;
			tick(1);
			drv_pm_req[k] = 1'h0;
			chk(drv_pm_ack, 4'h1 << k);
			cable_use_req[k] = 1'h1;
			w = 1'h0;
			n = 0;
			while (cable_grant[k] !== 1'h1 && n < 40)
			begin
				tick(1);
				n++;
				if (com_wake[k] === 1'h1)
					w = 1'h1;
			end
			cable_use_req[k] = 1'h0;
			chk(w, 1'h1);
			chk(n < 30, 1'h1);
		end
		// Port 2 is woken by the drive; no host wake is then needed.
		drv_pm_req[2] = 1'h1;
		tick(1);
		drv_pm_req[2] = 1'h0;
		phy_detect[2] = 1'h0;
		tick(1);
		chk(port_present_bit[2], 1'h1);
		drive_use[2] = 1'h1;
		tick(1);
		drive_use[2] = 1'h0;
		tick(2);
		cable_use_req[2] = 1'h1;
		tick(1);
		chk({com_wake[2], cable_grant[2]}, 2'h1);
		chk(port_present_bit[2], 1'h0);
		// A second reset mid-run brings back the power and trap defaults.
		set_pm(spg_pkg::PM_D3);
		rst = 1'h1;
		tick(2);
		rst = 1'h0;
		tick(1);
		chk(pm_state, spg_pkg::PM_RESET);
		chk(trap_en, spg_pkg::TRAP_EN_RESET);
		tally_and_finish;
	end
endmodule
`default_nettype wire
